// [inc/pcs_cfg_pkg.sv]
// Constants for the 100 Mb/s PCS configuration register, upper bits
//
// Operation
// - With the crossover bit set and speed forced, the pair assignment alternates while link is down and holds once it is up, else stays normal; reset is 0.
// - The free-run bit makes the receive clock free-running; at 0, its reset value, the clock phase follows data alignment.
// - The true-quiet bit selects true quiet transmit at 100 Mb/s; at 0, its reset value, transmit is normal.
// - The forced signal detect bit makes signal detect read as asserted whatever the input; at 0 detection is normal.
// - With the link detect option at 1, its reset value, link rises on valid signal plus lock and holds while signal stays valid.
// - With the link detect option at 0, link rises on valid signal plus lock and drops on loss of either.
// - The lock timeout is 722 us with the select bit at 0, its reset value, and 2 ms with it at 1.
// - The fiber mode bit resets to the fiber strap value, stays writable, and enables fiber operation when 1.
// - The register sits in the paged range 14h to 1Fh and is visible only while page 0 is selected.
package pcs_cfg_pkg;
  localparam logic [4:0] pcs_100m_config_status_addr = 5'h16;
  localparam logic [4:0] paged_low_addr = 5'h14;
  localparam logic [4:0] paged_high_addr = 5'h1F;
  localparam logic [2:0] page_zero = 3'h0;
  localparam int xover_bit = 15;
  localparam int free_clk_bit = 11;
  localparam int true_quiet_bit = 10;
  localparam int force_sd_bit = 9;
  localparam int link_opt_bit = 8;
  localparam int descrambler_timeout_select_bit = 7;
  localparam int fiber_bit = 6;
  localparam logic [15:0] writable_mask = 16'h8FC0;
  localparam logic [15:0] reset_value = 16'h0100;
  localparam int clk_mhz = 50;
  localparam int timeout_short_us = 722;
  localparam int timeout_long_ms = 2;
  localparam int timeout_short_cycles = timeout_short_us * clk_mhz;
  localparam int timeout_long_cycles = timeout_long_ms * 1000 * clk_mhz;
  // Alternation period between pair assignments in forced mode
  localparam int xover_period_us = 100;
  localparam int xover_period_cycles = xover_period_us * clk_mhz;
  localparam int count_width = 17;
endpackage

// [rtl/lock_timer.sv]
// Descrambler lock timeout counter
`timescale 1ns/1ps
module lock_timer
  import pcs_cfg_pkg::*;
#(
  parameter logic [count_width-1:0] short_limit = count_width'(timeout_short_cycles),
  parameter logic [count_width-1:0] long_limit = count_width'(timeout_long_cycles)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic long_sel,
  input wire logic restart,
  // Status
  output logic expired
);
  logic [count_width-1:0] count_reg;
  logic [count_width-1:0] count_next;
  wire logic [count_width-1:0] limit = long_sel ? long_limit : short_limit;
  wire logic at_limit = (count_reg >= limit);
  assign count_next = restart ? '0 :
                      at_limit ? count_reg : count_reg + 1'b1;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  assign expired = at_limit;
  timeout_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
    restart |=> !expired)
    else $error("timeout flagged right after restart");
endmodule // lock_timer

// [rtl/pcs_100m_config_upper.sv]
// Upper bits of the 100 Mb/s PCS configuration register and their effects
`timescale 1ns/1ps
module pcs_100m_config_upper
  import pcs_cfg_pkg::*;
#(
  parameter logic [count_width-1:0] short_limit = count_width'(timeout_short_cycles),
  parameter logic [count_width-1:0] long_limit = count_width'(timeout_long_cycles),
  parameter logic [count_width-1:0] xover_limit = count_width'(xover_period_cycles)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Strap, sampled on the reset cycles
  input wire logic fiber_strap,
  // Management register port
  input wire logic [4:0] reg_addr,
  input wire logic [2:0] page_select,
  input wire logic reg_write,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Mode inputs from the rest of the transceiver
  input wire logic speed_forced,
  // Medium inputs (asynchronous)
  input wire logic signal_level_in,
  input wire logic descrambler_lock_in,
  // Controls out
  output logic pair_crossed,
  output logic rx_clk_free_run,
  output logic true_quiet_transmit_enable,
  output logic signal_detect,
  output logic fiber_mode_enable,
  output logic descrambler_timeout,
  output logic link_up
);
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic [1:0] sig_sync_reg;
  logic [1:0] lock_sync_reg;
  logic link_reg;
  logic link_next;
  logic cross_reg;
  logic [count_width-1:0] xcnt_reg;
  logic [count_width-1:0] xcnt_next;
  logic lock_expired;

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  wire logic page_ok = (page_select == page_zero);
  wire logic hit = page_ok && (reg_addr == pcs_100m_config_status_addr);
  wire logic do_write = reg_write && hit;
  // Reserved bits 14:12 stay zero whatever is written
  assign cfg_next = do_write ? (reg_wdata & writable_mask) : cfg_reg;
  // Reads outside page 0 or other addresses return zero
  assign reg_rdata = hit ? cfg_reg : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Reset values, with the fiber bit copied from the strap
      cfg_reg <= reset_value | (16'(fiber_strap) << fiber_bit);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Fiber bit is taken from the strap while reset is held, then writable
  assign fiber_mode_enable = cfg_reg[fiber_bit];

  // ------------------------------------------------------------
  // Medium input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sig_sync_reg <= 2'h0;
      lock_sync_reg <= 2'h0;
    end else begin
      sig_sync_reg <= {sig_sync_reg[0], signal_level_in};
      lock_sync_reg <= {lock_sync_reg[0], descrambler_lock_in};
    end
  end

  // ------------------------------------------------------------
  // Signal detect and link
  // ------------------------------------------------------------
  wire logic sd_valid = cfg_reg[force_sd_bit] | sig_sync_reg[1];
  wire logic lock_ok = lock_sync_reg[1];
  wire logic hold_keep = cfg_reg[link_opt_bit] ? sd_valid
                                                : (sd_valid && lock_ok);
  assign link_next = link_reg ? hold_keep : (sd_valid && lock_ok);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link_reg <= 1'b0;
    end else begin
      link_reg <= link_next;
    end
  end
  assign signal_detect = sd_valid;
  assign link_up = link_reg;

  // Timer restarts whenever lock is present; expiry means lock was lost
  lock_timer #(
    .short_limit(short_limit),
    .long_limit(long_limit)
  ) u_lock_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .long_sel(cfg_reg[descrambler_timeout_select_bit]),
    .restart(lock_ok),
    .expired(lock_expired)
  );
  assign descrambler_timeout = lock_expired;

  // ------------------------------------------------------------
  // Forced-mode crossover
  // ------------------------------------------------------------
  // Alternation pauses once link is found so the working pair sticks
  wire logic xover_on = cfg_reg[xover_bit] && speed_forced && !link_reg;
  wire logic xwrap = (xcnt_reg >= xover_limit);
  assign xcnt_next = (!xover_on || xwrap) ? '0 : xcnt_reg + 1'b1;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      xcnt_reg <= '0;
      cross_reg <= 1'b0;
    end else begin
      xcnt_reg <= xcnt_next;
      if (!(cfg_reg[xover_bit] && speed_forced)) begin
        cross_reg <= 1'b0;
      end else if (xover_on && xwrap) begin
        cross_reg <= ~cross_reg;
      end
    end
  end
  assign pair_crossed = cross_reg;

  assign rx_clk_free_run = cfg_reg[free_clk_bit];
  assign true_quiet_transmit_enable = cfg_reg[true_quiet_bit];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  reserved_zero_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    cfg_reg[14:12] == 3'h0)
    else $error("reserved bits not zero");
  page_hide_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    !page_ok |-> reg_rdata == 16'h0000)
    else $error("register visible off page 0");
  off_addr_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    reg_addr != pcs_100m_config_status_addr |-> reg_rdata == 16'h0000)
    else $error("register visible at another address");
  page_write_block_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    reg_write && !page_ok |=> $stable(cfg_reg))
    else $error("write taken off page 0");
  write_take_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    do_write |=> rx_clk_free_run == $past(reg_wdata[free_clk_bit]))
    else $error("free run bit did not take write");
  quiet_take_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    do_write |=> true_quiet_transmit_enable ==
      $past(reg_wdata[true_quiet_bit]))
    else $error("true quiet bit did not take write");
  force_sd_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    cfg_reg[force_sd_bit] |-> signal_detect)
    else $error("forced signal detect not asserted");
  sd_follow_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    !cfg_reg[force_sd_bit] |-> signal_detect == sig_sync_reg[1])
    else $error("signal detect not following the medium");
  link_rise_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    !link_reg && sd_valid && lock_ok |=> link_reg)
    else $error("link not raised on signal and lock");
  link_stay_down_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    !link_reg && !(sd_valid && lock_ok) |=> !link_reg)
    else $error("link raised without signal and lock");
  link_hold_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    link_reg && cfg_reg[link_opt_bit] && sd_valid |=> link_reg)
    else $error("link dropped with valid signal");
  link_sig_drop_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    link_reg && !sd_valid |=> !link_reg)
    else $error("link kept without valid signal");
  link_drop_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    link_reg && !cfg_reg[link_opt_bit] && !lock_ok |=> !link_reg)
    else $error("link kept without lock");
  timeout_cause_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    descrambler_timeout |-> !$past(lock_ok))
    else $error("timeout flagged while lock was present");
  reset_default_a: assert property (@(posedge clk_sys)
    $fell(reset) |->
      cfg_reg[xover_bit:descrambler_timeout_select_bit] == reset_value[xover_bit:descrambler_timeout_select_bit])
    else $error("register not at its reset value");
  strap_load_a: assert property (@(posedge clk_sys)
    $fell(reset) |-> fiber_mode_enable == $past(fiber_strap))
    else $error("fiber bit not loaded from the strap");
  fiber_take_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    do_write |=> fiber_mode_enable == $past(reg_wdata[fiber_bit]))
    else $error("fiber bit did not take write");
  fiber_hold_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    !do_write |=> $stable(fiber_mode_enable))
    else $error("fiber bit changed without a write");
  xover_off_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    !cfg_reg[xover_bit] |=> !pair_crossed)
    else $error("pairs crossed with crossover off");
  cross_toggle_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    xover_on && xwrap |=> pair_crossed != $past(pair_crossed))
    else $error("pair assignment did not alternate");
  cross_hold_a: assert property (@(posedge clk_sys)
    disable iff (reset)
    link_reg && cfg_reg[xover_bit] && speed_forced |=> $stable(pair_crossed))
    else $error("pair assignment moved while link is up");
endmodule // pcs_100m_config_upper

// [test/pcs_100m_config_upper_bench.sv]
// Self-checking bench for the upper PCS configuration register bits
`timescale 1ns/1ps
module pcs_100m_config_upper_bench;
  import pcs_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic fiber_strap = 1'b1;
  logic [4:0] reg_addr = pcs_100m_config_status_addr;
  logic [2:0] page_select = page_zero;
  logic reg_write = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic speed_forced = 1'b0;
  logic signal_level_in = 1'b0;
  logic descrambler_lock_in = 1'b1;
  logic pair_crossed, rx_clk_free_run, true_quiet_transmit_enable;
  logic signal_detect, fiber_mode_enable, descrambler_timeout, link_up;
  logic probe = 1'b0;
  logic probe_sel = 1'b0;
  logic last_pair;
  logic [15:0] wd;
  logic [15:0] exp_q[$];
  string name_q[$];
  int n_fail = 0;
  int comparisons = 0;
  int seed = 93177;
  int toggles;
  wire logic [15:0] outs = {9'h000, link_up, descrambler_timeout,
    fiber_mode_enable, signal_detect, true_quiet_transmit_enable,
    rx_clk_free_run, pair_crossed};
  always #10 clk_sys = ~clk_sys;
  // Short limits keep the timeout scenarios to a few dozen cycles
  pcs_100m_config_upper #(.short_limit(17'd20), .long_limit(17'd50),
    .xover_limit(17'd8)) DUT (.clk_sys(clk_sys), .reset(reset),
    .fiber_strap(fiber_strap), .reg_addr(reg_addr),
    .page_select(page_select), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .speed_forced(speed_forced), .signal_level_in(signal_level_in),
    .descrambler_lock_in(descrambler_lock_in), .pair_crossed(pair_crossed),
    .rx_clk_free_run(rx_clk_free_run),
    .true_quiet_transmit_enable(true_quiet_transmit_enable),
    .signal_detect(signal_detect), .fiber_mode_enable(fiber_mode_enable),
    .descrambler_timeout(descrambler_timeout), .link_up(link_up));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input string nm, input logic [15:0] s,
    input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [15:0] outs_for(input logic lk, input logic to,
    input logic [15:0] r, input logic sg);
    return {9'h000, lk, to, r[6], r[9] | sg, r[10], r[11], 1'b0};
  endfunction
  // Note sits in the queue until the monitor samples the next rising edge
  task automatic expect_val(input logic sel, input string nm,
    input logic [15:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    probe_sel = sel;
    probe = 1'b1;
    @(posedge clk_sys);
    probe <= 1'b0;
    @(negedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (probe) begin
      check(name_q.pop_front(), probe_sel ? reg_rdata : outs,
        exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] pg, input logic [15:0] d);
    page_select = pg;
    reg_wdata = d;
    reg_write = 1'b1;
    cyc(1);
    reg_write = 1'b0;
    page_select = page_zero;
    cyc(1);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    finish_test;
  end
  initial begin
    cyc(2);
    reset = 1'b0;
    expect_val(1'b1, "reset_read", reset_value | 16'h0040);
    expect_val(1'b0, "reset_outs", 16'h0010);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      wd = 16'($random(seed)) & 16'h8FFF;
      wr(page_zero, wd);
      expect_val(1'b1, "readback", wd & writable_mask);
      expect_val(1'b0, "ctrl_outs", outs_for(wd[9], 0, wd, 0));
    end
    wr(3'h1, 16'h8FC0);
    expect_val(1'b1, "other_page_write", wd & writable_mask);
    page_select = 3'h1;
    expect_val(1'b1, "other_page_read", 16'h0000);
    page_select = page_zero;
    reg_addr = paged_low_addr;
    expect_val(1'b1, "other_addr_read", 16'h0000);
    reg_addr = pcs_100m_config_status_addr;
    $display("register test done");
    for (int k = 1; k >= 0; k--) begin
      wd = k ? 16'h0100 : 16'h0000;
      wr(page_zero, wd);
      signal_level_in = 1'b1;
      cyc(5);
      expect_val(1'b0, "link_rise", outs_for(1, 0, wd, 1));
      descrambler_lock_in = 1'b0;
      cyc(5);
      expect_val(1'b0, "lock_loss", outs_for(k, 0, wd, 1));
      signal_level_in = 1'b0;
      descrambler_lock_in = 1'b1;
      cyc(5);
      expect_val(1'b0, "signal_loss", outs_for(0, 0, wd, 0));
    end
    $display("link test done");
    for (int k = 0; k < 2; k++) begin
      wd = k ? 16'h0080 : 16'h0000;
      wr(page_zero, wd);
      descrambler_lock_in = 1'b0;
      cyc(k ? 40 : 15);
      expect_val(1'b0, "timeout_early", outs_for(0, 0, wd, 0));
      cyc(k ? 16 : 11);
      expect_val(1'b0, "timeout_late", outs_for(0, 1, wd, 0));
      descrambler_lock_in = 1'b1;
      cyc(5);
    end
    $display("timeout test done");
    wr(page_zero, 16'h8000);
    speed_forced = 1'b1;
    toggles = 0;
    last_pair = pair_crossed;
    for (int i = 0; i < 24; i++) begin
      cyc(1);
      toggles += int'(pair_crossed !== last_pair);
      last_pair = pair_crossed;
    end
    check("pair_toggles", 16'(toggles >= 2 && toggles <= 4), 16'h0001);
    // Once link is up the pair assignment must stay put
    signal_level_in = 1'b1;
    cyc(4);
    last_pair = pair_crossed;
    cyc(20);
    check("pair_hold", {15'h0000, pair_crossed}, {15'h0000, last_pair});
    signal_level_in = 1'b0;
    speed_forced = 1'b0;
    $display("crossover test done");
    fiber_strap = 1'b0;
    // Reset stands in for the soft reset that follows a fiber change
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    expect_val(1'b1, "strap_low_read", reset_value);
    expect_val(1'b0, "strap_low_outs", 16'h0000);
    $display("strap test done");
    finish_test;
  end
endmodule // pcs_100m_config_upper_bench
